// [core/tmr_pkg.sv]
/*
  Package for the three-channel timer/counter count gating block.
  Assumes a core clock with machine cycles of twelve core clocks.
*/
package tmr_pkg;
  localparam int CLK_PER_MC = 12;
  localparam int MC_W = 4;
  localparam logic [7:0] MODE_CFG_ADDR = 8'h89;
  localparam logic [7:0] MODE_CFG_RESET = 8'h00;
  localparam int MC_GATE1 = 7;
  localparam int MC_CSEL1 = 6;
  localparam int MC_MODEH1 = 5;
  localparam int MC_MODEL1 = 4;
  localparam int MC_GATE0 = 3;
  localparam int MC_CSEL0 = 2;
  localparam int MC_MODEH0 = 1;
  localparam int MC_MODEL0 = 0;
  // Sample phase S5P2 and update phase S3P1 as core clock slots 0..11
  localparam logic [3:0] PH_SAMPLE = 4'h9;
  localparam logic [3:0] PH_UPDATE = 4'h4;
  localparam logic [3:0] PH_LAST = 4'hB;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  typedef struct packed {
    logic [7:0] countHigh;
    logic [7:0] countLow;
  } count_t;

  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } reg_wr_t;
endpackage

// [core/count_channel.sv]
/*
  One 16-bit timer/counter channel: edge sampling, gating, increment.
  Assumes phase strobes from a shared machine-cycle sequencer.
*/
`timescale 1ns/1ps
module count_channel (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic phSample,
  input wire logic phUpdate,
  input wire logic mcEnd,
  input wire logic counterSel,
  input wire logic gateEn,
  input wire logic runBit,
  input wire logic gatePin,
  input wire logic eventPin,
  output tmr_pkg::count_t count
);
  logic sampleNow_q;
  logic samplePrev_q;
  logic edgePend_q;
  logic timerTick_q;
  tmr_pkg::count_t count_q;
  logic enable;

  assign enable = runBit & (~gateEn | gatePin);
  assign count = count_q;

  // Pin sampled once per machine cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sampleNow_q <= 1'b0;
      samplePrev_q <= 1'b0;
    end else if (phSample) begin
      sampleNow_q <= eventPin; // R3
      samplePrev_q <= sampleNow_q;
    end
  end

  // High then low across two samples marks one event; flagged at the machine-cycle end, two clocks after sampling
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      edgePend_q <= 1'b0;
    end else if (phUpdate) begin
      edgePend_q <= 1'b0;
    end else if (mcEnd) begin
      edgePend_q <= samplePrev_q & ~sampleNow_q; // R3 R5
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timerTick_q <= 1'b0;
    end else begin
      timerTick_q <= mcEnd;
    end
  end

  // Event increment applied at the update phase of the following cycle; timer increment one clock after mcEnd
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_q <= tmr_pkg::COUNT_RESET;
    end else if (enable && ((counterSel && phUpdate && edgePend_q) || (!counterSel && timerTick_q))) begin // R2 R4 R8 R10
      count_q.countLow <= count_q.countLow + 8'h01;
      if (count_q.countLow == 8'hFF) begin
        count_q.countHigh <= count_q.countHigh + 8'h01; // R11
      end
    end
  end
endmodule // count_channel

// [core/timer_counter_count_gating.sv]
/*
  Counting front end for three 16-bit timer/counters with mode register.
  Assumes synchronous pins and a core write port on the special function bus.
*/
// Summary of operation
// R1: Three independent 16-bit counters, each a low and high byte.
// R2: Timer function increments once per twelve-clock machine cycle.
// R3: Counter function samples pin each machine cycle, counts high-then-low.
// R4: Counted value appears at update phase of the cycle after detection.
// R5: Edge recognition takes two machine cycles, max one count per 24 clocks.
// R6: Pin source must hold each level at least one machine cycle.
// R7: Mode register at 89H resets to 00H; third timer uses its own control.
// R8: Bit 7 set gates counter one with its interrupt pin and run bit.
// R9: Bit 6 selects pin edge counting for counter one, else timer.
// R10: Bit 3 clear lets counter zero run from run bit alone.
// R11: Low byte wrapping from FF carries into the high byte.
`timescale 1ns/1ps
module timer_counter_count_gating (
  input wire logic clk,
  input wire logic rst_b,
  input tmr_pkg::reg_wr_t regWr,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData,
  input wire logic timer_zero_run_bit,
  input wire logic timer_one_run_bit,
  input wire logic timer_two_run_bit,
  input wire logic timer_two_counter_sel,
  input wire logic timer_zero_event_pin,
  input wire logic timer_one_event_pin,
  input wire logic timer_two_event_pin,
  input wire logic ext_irq_zero_pin,
  input wire logic ext_irq_one_pin,
  output tmr_pkg::count_t count0,
  output tmr_pkg::count_t count1,
  output tmr_pkg::count_t count2
);
  logic [7:0] timer_mode_config_q;
  logic [3:0] phase_q;
  logic phSample;
  logic phUpdate;
  logic mcEnd;
  tmr_pkg::count_t cnt0;
  tmr_pkg::count_t cnt1;
  tmr_pkg::count_t cnt2;

  ////////////////////////////////////////////////////////////////////////
  // Mode register, write and read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timer_mode_config_q <= tmr_pkg::MODE_CFG_RESET; // R7
    end else if (regWr.wrEn && regWr.addr == tmr_pkg::MODE_CFG_ADDR) begin
      timer_mode_config_q <= regWr.wrData; // R7
    end
  end

  // Unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdData <= 8'h00;
    end else if (rdAddr == tmr_pkg::MODE_CFG_ADDR) begin
      rdData <= timer_mode_config_q;
    end else begin
      rdData <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Machine-cycle sequencer: twelve core clocks per cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase_q <= 4'h0;
    end else if (phase_q == tmr_pkg::PH_LAST) begin
      phase_q <= 4'h0; // R2
    end else begin
      phase_q <= phase_q + 4'h1;
    end
  end

  assign phSample = (phase_q == tmr_pkg::PH_SAMPLE);
  assign phUpdate = (phase_q == tmr_pkg::PH_UPDATE);
  assign mcEnd = (phase_q == tmr_pkg::PH_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Channels; relies on pin sources holding levels a full machine cycle
  count_channel chan0 (
    .clk(clk),
    .rst_b(rst_b),
    .phSample(phSample),
    .phUpdate(phUpdate),
    .mcEnd(mcEnd),
    .counterSel(timer_mode_config_q[tmr_pkg::MC_CSEL0]),
    .gateEn(timer_mode_config_q[tmr_pkg::MC_GATE0]), // R10
    .runBit(timer_zero_run_bit),
    .gatePin(ext_irq_zero_pin),
    .eventPin(timer_zero_event_pin), // R6
    .count(cnt0)
  );

  count_channel chan1 (
    .clk(clk),
    .rst_b(rst_b),
    .phSample(phSample),
    .phUpdate(phUpdate),
    .mcEnd(mcEnd),
    .counterSel(timer_mode_config_q[tmr_pkg::MC_CSEL1]), // R9
    .gateEn(timer_mode_config_q[tmr_pkg::MC_GATE1]), // R8
    .runBit(timer_one_run_bit),
    .gatePin(ext_irq_one_pin),
    .eventPin(timer_one_event_pin),
    .count(cnt1)
  );

  // Third channel configured by its own control inputs, never gated
  count_channel chan2 (
    .clk(clk),
    .rst_b(rst_b),
    .phSample(phSample),
    .phUpdate(phUpdate),
    .mcEnd(mcEnd),
    .counterSel(timer_two_counter_sel), // R7
    .gateEn(1'b0),
    .runBit(timer_two_run_bit),
    .gatePin(1'b1),
    .eventPin(timer_two_event_pin),
    .count(cnt2)
  );

  // Registered outputs, one clock behind the channel counts
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count0 <= tmr_pkg::COUNT_RESET; // R1
      count1 <= tmr_pkg::COUNT_RESET;
      count2 <= tmr_pkg::COUNT_RESET;
    end else begin
      count0 <= cnt0;
      count1 <= cnt1;
      count2 <= cnt2;
    end
  end
endmodule // timer_counter_count_gating

// [testbench/tcg_props.sv]
/* Port assertions for the count gating block.
   Bound into its top module; one clock domain. */
`timescale 1ns/1ps
module tcg_props (
  input wire logic clk,
  input wire logic rst_b,
  input tmr_pkg::reg_wr_t regWr,
  input wire logic [7:0] rdAddr,
  input wire logic [7:0] rdData,
  input wire logic timer_zero_run_bit,
  input wire logic timer_one_run_bit,
  input wire logic timer_one_event_pin,
  input wire logic ext_irq_one_pin,
  input tmr_pkg::count_t count0,
  input tmr_pkg::count_t count1
);
  logic [7:0] mode_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Shadow of the mode register, so gating can be judged
  always_ff @(posedge clk) begin
    if (!rst_b) mode_q <= 8'h00;
    else if (regWr.wrEn && regWr.addr == 8'h89) mode_q <= regWr.wrData;
  end
  //////////////////////////////////////////////////
  property p_step; $changed(count0) |-> count0 == $past(count0) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("step");
  property p_gap; $changed(count0) |=> !$changed(count0) [*8]; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  // Enable is judged at the internal increment edge, two edges before the port change is seen
  property p_run0; $changed(count0) |-> $past(timer_zero_run_bit, 2); endproperty
  a_run0: assert property (p_run0) else $error("run0");
  property p_run1; $changed(count1) |-> $past(timer_one_run_bit, 2); endproperty
  a_run1: assert property (p_run1) else $error("run1");
  property p_gate; $changed(count1) && $past(mode_q[7], 2) |-> $past(ext_irq_one_pin, 2); endproperty
  a_gate: assert property (p_gate) else $error("gate");
  // Low sample 9 edges back, high sample one machine cycle before it
  property p_fall; $changed(count1) && $past(mode_q[6], 2) |->
    $past(timer_one_event_pin, 21) && !$past(timer_one_event_pin, 9); endproperty
  a_fall: assert property (p_fall) else $error("fall");
  property p_rd; $past(rdAddr) == 8'h89 && $stable(mode_q) |-> rdData == mode_q; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_rd0; $past(rdAddr) != 8'h89 |-> rdData == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("read0");
endmodule // tcg_props
bind timer_counter_count_gating tcg_props chk (.clk, .rst_b, .regWr, .rdAddr, .rdData, .timer_zero_run_bit,
  .timer_one_run_bit, .timer_one_event_pin, .ext_irq_one_pin, .count0, .count1);

// [testbench/pin_source.sv]
/* Pulse source on the count input pins.
   Assumes the bench gates it on the core clock. */
`timescale 1ns/1ps
module pin_source (
  input wire logic clk,
  input wire logic en,
  output logic pin
);
  logic [3:0] tick_q = 4'h0;
  logic level_q = 1'b0;
  assign pin = level_q;
  //////////////////////////////////////////////////
  // One machine cycle per level: fastest legal rate
  always @(posedge clk) begin
    if (en) begin
      tick_q <= (tick_q == 4'hB) ? 4'h0 : tick_q + 4'h1;
      if (tick_q == 4'hB) level_q <= !level_q;
    end
  end
endmodule // pin_source

// [testbench/timer_counter_count_gating_test.sv]
/* Bench: mode register, timer, gate and pin counting.
   Assumes one pulse source drives all three count pins. */
`timescale 1ns/1ps
module timer_counter_count_gating_test;
  logic clk, rst_b, run0, run1, run2, sel2, irq0, irq1, srcEn, evPin;
  logic [7:0] rdAddr, rdData, d;
  tmr_pkg::reg_wr_t regWr;
  tmr_pkg::count_t count0, count1, count2, c0, c1, c2, g0, g1, g2;
  int err_total = 0, compares = 0, cyc = 0;
  timer_counter_count_gating uut (.clk, .rst_b, .regWr, .rdAddr, .rdData, .timer_zero_run_bit(run0),
    .timer_one_run_bit(run1), .timer_two_run_bit(run2), .timer_two_counter_sel(sel2),
    .timer_zero_event_pin(evPin), .timer_one_event_pin(evPin), .timer_two_event_pin(evPin),
    .ext_irq_zero_pin(irq0), .ext_irq_one_pin(irq1), .count0, .count1, .count2);
  pin_source src (.clk, .en(srcEn), .pin(evPin));
  //////////////////////////////////////////////////
  task automatic close_out();
    $display("%0d compares, %0d errors", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    regWr <= '{1'b1, a, v};
    @(posedge clk);
    regWr.wrEn <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    rdAddr <= a;
    repeat (2) @(posedge clk);
    d = rdData;
  endtask
  // Counts read at the falling edge, where they are settled; returns on a rising edge
  task automatic grab();
    @(negedge clk);
    g0 = count0;
    g1 = count1;
    g2 = count2;
    @(posedge clk);
  endtask
  // Settle a machine cycle, then two reads exactly n rising edges apart
  task automatic snap(input int n);
    repeat (12) @(posedge clk);
    grab();
    c0 = g0;
    c1 = g1;
    c2 = g2;
    repeat (n - 1) @(posedge clk);
    grab();
  endtask
  task automatic t_reg();
    rd(8'h89);
    chk("mode reset", 16'h0000, d);
    wr(8'h89, 8'hC5);
    rd(8'h89);
    chk("mode write", 16'h00C5, d);
    wr(8'h88, 8'h3A);
    rd(8'h89);
    chk("other addr", 16'h00C5, d);
    rd(8'h88);
    chk("unmapped", 16'h0000, d);
    $display("t_reg done");
  endtask
  task automatic t_timer();
    wr(8'h89, 8'h00);
    run0 <= 1'b1;
    snap(3120);
    chk("timer0", c0 + 16'h0104, g0);
    run0 <= 1'b0;
    snap(48);
    chk("timer0 off", c0, g0);
    $display("t_timer done");
  endtask
  task automatic t_gate();
    wr(8'h89, 8'h80);
    run1 <= 1'b1;
    snap(120);
    chk("gate low", c1, g1);
    irq1 <= 1'b1;
    snap(120);
    chk("gate high", c1 + 16'h000A, g1);
    $display("t_gate done");
  endtask
  task automatic t_count();
    wr(8'h89, 8'h44);
    {run0, run1, run2, sel2, irq1} <= 5'h1E;
    snap(1);
    srcEn <= 1'b1;
    repeat (480) @(posedge clk);
    srcEn <= 1'b0;
    repeat (48) @(posedge clk);
    grab();
    chk("events1", c1 + 16'h0014, g1);
    chk("events0", c0 + 16'h0014, g0);
    chk("events2", c2 + 16'h0014, g2);
    $display("t_count done");
  endtask
  //////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst_b, run0, run1, run2, sel2, irq0, irq1, srcEn} = 8'h00;
    regWr = '0;
    rdAddr = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reg();
    t_timer();
    t_gate();
    t_count();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reg();
    close_out();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      err_total++;
      close_out();
    end
  end
endmodule // timer_counter_count_gating_test
